// ==== rtl/tmr_pair.sv ====
/*
 Two 8-bit timer channels (timer, event counter, 7-bit PWM) behind APB.
 Assumes event and low-frequency clock pins are asynchronous to clk_sys.
*/
// Local design decision: register access over APB.
`timescale 1ns/100ps
module tmr_pair
   import tmr_pair_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input apb_req_t apb_req,
   output apb_rsp_t apb_rsp,
   input wire logic [1:0] event_pin,
   input wire logic lf_clk_pin,
   output logic [1:0] pwm_output_pin,
   output logic [1:0] match_interrupt
);

   function automatic ch_fn_t fn_decode(mode_t m, logic cas);
      ch_fn_t f;
      f = FN_IDLE;
      if (!cas) begin
         case (m.tcm)
            TCM_PWM: f = FN_PWM;
            TCM_PPG: f = FN_IDLE;
            default: f = m.ein ? FN_EVENT : FN_TIMER;
         endcase
      end
      return f;
   endfunction : fn_decode

   function automatic logic src_tick(mode_t m, logic [10:0] pre,
         logic [2:0] lft, logic lfdiv, logic slow, logic fall);
      logic t;
      t = 1'b0;
      if (m.ein) begin
         t = fall;
      end else if (slow) begin
         case (m.tck)
            3'b000: t = lft[2];
            3'b001: t = lft[1];
            3'b111: t = lft[0];
            default: t = 1'b0;
         endcase
      end else begin
         case (m.tck)
            3'b000: t = lfdiv ? lft[2] : &pre[10:0];
            3'b001: t = lfdiv ? lft[1] : &pre[9:0];
            3'b010: t = &pre[7:0];
            3'b011: t = &pre[5:0];
            3'b100: t = &pre[3:0];
            3'b101: t = &pre[1:0];
            3'b110: t = pre[0];
            default: t = 1'b1;
         endcase
      end
      return t;
   endfunction : src_tick

   // pin synchronisers and prescalers
   logic [1:0] evt_s1_r, evt_s2_r, evt_d_r;
   logic [1:0] evt_s1_nxt, evt_s2_nxt, evt_d_nxt, evt_fall;
   logic lf_s1_r, lf_s2_r, lf_d_r, lf_s1_nxt, lf_s2_nxt, lf_d_nxt, lf_edge;
   logic [3:0] lf_cnt_r, lf_cnt_nxt;
   logic [10:0] pre_r, pre_nxt;
   logic [2:0] lft;

   always_comb begin
      evt_s1_nxt = event_pin;
      evt_s2_nxt = evt_s1_r;
      evt_d_nxt = evt_s2_r;
      lf_s1_nxt = lf_clk_pin;
      lf_s2_nxt = lf_s1_r;
      lf_d_nxt = lf_s2_r;
      evt_fall = evt_d_r & ~evt_s2_r;
      lf_edge = lf_s2_r & ~lf_d_r;
      lf_cnt_nxt = lf_cnt_r + {3'b000, lf_edge};
      pre_nxt = pre_r + 11'h001;
      lft[2] = lf_edge && (lf_cnt_r == LF_DIV16);
      lft[1] = lf_edge && ((lf_cnt_r & LF_DIV8) == LF_DIV8);
      lft[0] = lf_edge && ((lf_cnt_r & LF_DIV4) == LF_DIV4);
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         evt_s1_r <= 2'b11;
         evt_s2_r <= 2'b11;
         evt_d_r <= 2'b11;
         lf_s1_r <= 1'b0;
         lf_s2_r <= 1'b0;
         lf_d_r <= 1'b0;
         lf_cnt_r <= 4'h0;
         pre_r <= 11'h000;
      end else begin
         evt_s1_r <= evt_s1_nxt;
         evt_s2_r <= evt_s2_nxt;
         evt_d_r <= evt_d_nxt;
         lf_s1_r <= lf_s1_nxt;
         lf_s2_r <= lf_s2_nxt;
         lf_d_r <= lf_d_nxt;
         lf_cnt_r <= lf_cnt_nxt;
         pre_r <= pre_nxt;
      end
   end

   // registers and channel state
   logic [7:0] cnt_r [2], cnt_nxt [2];
   logic [7:0] cmp_act_r [2], cmp_act_nxt [2], cmp_buf_r [2], cmp_buf_nxt [2];
   logic [7:0] pwm_act_r [2], pwm_act_nxt [2], pwm_buf_r [2], pwm_buf_nxt [2];
   mode_t mode_r [2], mode_nxt [2];
   ch_fn_t fn_c [2];
   logic [7:0] tgt_c [2];
   logic [1:0] tog_r, tog_nxt, per_r, per_nxt, wr_chk_r, wr_chk_nxt;
   logic [1:0] irq_nxt, tk_c, match_c, out_c, pin_nxt;
   logic [1:0] run_r, run_nxt, sys_r, sys_nxt;
   logic cas_r, cas_nxt, and_r, and_nxt, acc_wr, setup;
   logic [9:0] idx;
   logic [7:0] wdat, rval;
   apb_rsp_t rsp_nxt;

   always_comb begin
      idx = apb_req.paddr[AW-1:2];
      wdat = apb_req.pwdata[7:0];
      setup = apb_req.psel & ~apb_req.penable;
      acc_wr = apb_req.psel & apb_req.penable & apb_req.pwrite &
         apb_rsp.pready & (apb_req.paddr[1:0] == 2'b00);
      run_nxt = run_r;
      cas_nxt = cas_r;
      and_nxt = and_r;
      sys_nxt = sys_r;
      if (acc_wr && idx == IDX_PCTRL) begin
         run_nxt = wdat[PC_RUN0 +: 2];
         // cascade and AND select only move while both channels stop
         if (run_r == 2'b00) begin
            cas_nxt = wdat[PC_CAS];
            and_nxt = wdat[PC_AND];
         end
      end
      if (acc_wr && idx == IDX_SYS) begin
         sys_nxt = wdat[1:0];
      end
      for (int i = 0; i < 2; i++) begin
         cnt_nxt[i] = cnt_r[i];
         cmp_act_nxt[i] = cmp_act_r[i];
         cmp_buf_nxt[i] = cmp_buf_r[i];
         pwm_act_nxt[i] = pwm_act_r[i];
         pwm_buf_nxt[i] = pwm_buf_r[i];
         mode_nxt[i] = mode_r[i];
         tog_nxt[i] = tog_r[i];
         per_nxt[i] = per_r[i];
         wr_chk_nxt[i] = 1'b0;
         irq_nxt[i] = 1'b0;
         match_c[i] = 1'b0;
         fn_c[i] = fn_decode(mode_r[i], cas_r);
         tk_c[i] = src_tick(mode_r[i], pre_r, lft, sys_r[SC_LFDIV],
            sys_r[SC_SLOW], evt_fall[i]);
         tgt_c[i] = {1'b0, pwm_act_r[i][7:PWM_DUTY0]} +
            {7'h00, pwm_act_r[i][PWM_AD] & per_r[i]};
         out_c[i] = mode_r[i].tff;
         case (fn_c[i])
            FN_TIMER, FN_EVENT: begin
               // a fresh write re-checks equality off the tick grid
               match_c[i] = run_r[i] && cnt_r[i] == cmp_act_r[i] &&
                  (tk_c[i] || wr_chk_r[i]);
               if (match_c[i]) begin
                  cnt_nxt[i] = CNT_ZERO;
                  irq_nxt[i] = 1'b1;
                  if (mode_r[i].dbe) begin
                     cmp_act_nxt[i] = cmp_buf_r[i];
                  end
               end else if (run_r[i] && tk_c[i]) begin
                  cnt_nxt[i] = cnt_r[i] + 8'h01;
               end
               if (run_r[i]) begin
                  out_c[i] = 1'b1;
               end
            end
            FN_PWM: begin
               if (run_r[i] && tk_c[i] && cnt_r[i] == PWM_LAST) begin
                  cnt_nxt[i] = CNT_ZERO;
                  tog_nxt[i] = 1'b0;
                  per_nxt[i] = ~per_r[i];
                  if (per_r[i]) begin
                     irq_nxt[i] = 1'b1;
                     if (mode_r[i].dbe) begin
                        pwm_act_nxt[i] = pwm_buf_r[i];
                     end
                  end
               end else if (run_r[i]) begin
                  if (tk_c[i]) begin
                     cnt_nxt[i] = cnt_r[i] + 8'h01;
                  end
                  if (cnt_r[i] == tgt_c[i]) begin
                     tog_nxt[i] = 1'b1;
                  end
               end
               if (run_r[i]) begin
                  out_c[i] = mode_r[i].tff ^ tog_r[i];
               end
            end
            default: ;
         endcase
         if (!run_nxt[i]) begin
            cnt_nxt[i] = CNT_ZERO;
            tog_nxt[i] = 1'b0;
            per_nxt[i] = 1'b0;
         end
         if (acc_wr && idx == IDX_CMP[i]) begin
            cmp_buf_nxt[i] = wdat;
            if (!mode_r[i].dbe || !run_r[i]) begin
               cmp_act_nxt[i] = wdat;
               wr_chk_nxt[i] = 1'b1;
            end
         end
         if (acc_wr && idx == IDX_PWM[i]) begin
            pwm_buf_nxt[i] = wdat;
            if (!mode_r[i].dbe || !run_r[i]) begin
               pwm_act_nxt[i] = wdat;
            end
         end
         if (acc_wr && idx == IDX_MODE[i] && !run_r[i]) begin
            mode_nxt[i] = mode_t'(wdat);
         end
      end
      pin_nxt[0] = and_r ? 1'b1 : out_c[0];
      pin_nxt[1] = and_r ? (out_c[0] & out_c[1]) : out_c[1];
      rval = 8'h00;
      rsp_nxt = apb_rsp;
      rsp_nxt.pready = setup;
      if (setup) begin
         rsp_nxt.pslverr = apb_req.paddr[1:0] != 2'b00;
         case (idx)
            IDX_CMP[0]: rval = cmp_buf_r[0];
            IDX_CMP[1]: rval = cmp_buf_r[1];
            IDX_MODE[0]: rval = mode_r[0];
            IDX_MODE[1]: rval = mode_r[1];
            IDX_CNT[0]: rval = cnt_r[0];
            IDX_CNT[1]: rval = cnt_r[1];
            IDX_PWM[0]: rval = pwm_buf_r[0];
            IDX_PWM[1]: rval = pwm_buf_r[1];
            IDX_PCTRL: rval = {4'h0, and_r, cas_r, run_r};
            IDX_SYS: rval = {6'h00, sys_r};
            default: rsp_nxt.pslverr = 1'b1;
         endcase
         rsp_nxt.prdata = {24'h000000, rval};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         for (int i = 0; i < 2; i++) begin
            cnt_r[i] <= CNT_ZERO;
            cmp_act_r[i] <= RST_CMP;
            cmp_buf_r[i] <= RST_CMP;
            pwm_act_r[i] <= RST_PWM;
            pwm_buf_r[i] <= RST_PWM;
            mode_r[i] <= RST_MODE;
         end
         tog_r <= 2'b00;
         per_r <= 2'b00;
         wr_chk_r <= 2'b00;
         run_r <= 2'b00;
         sys_r <= 2'b00;
         cas_r <= 1'b0;
         and_r <= 1'b0;
         match_interrupt <= 2'b00;
         pwm_output_pin <= 2'b00;
         apb_rsp <= '0;
      end else begin
         cnt_r <= cnt_nxt;
         cmp_act_r <= cmp_act_nxt;
         cmp_buf_r <= cmp_buf_nxt;
         pwm_act_r <= pwm_act_nxt;
         pwm_buf_r <= pwm_buf_nxt;
         mode_r <= mode_nxt;
         tog_r <= tog_nxt;
         per_r <= per_nxt;
         wr_chk_r <= wr_chk_nxt;
         run_r <= run_nxt;
         sys_r <= sys_nxt;
         cas_r <= cas_nxt;
         and_r <= and_nxt;
         match_interrupt <= irq_nxt;
         pwm_output_pin <= pin_nxt;
         apb_rsp <= rsp_nxt;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence dbuf_wr_s;
      acc_wr && idx == IDX_CMP[0] && run_r[0] && mode_r[0].dbe && !match_c[0];
   endsequence
   sequence first_ovf_s;
      fn_c[0] == FN_PWM && run_r[0] && run_nxt[0] && tk_c[0] &&
         cnt_r[0] == PWM_LAST && !per_r[0];
   endsequence
   sequence eq_wr_s;
      wr_chk_r[0] && run_r[0] && cnt_r[0] == cmp_act_r[0] &&
         (fn_c[0] == FN_TIMER || fn_c[0] == FN_EVENT);
   endsequence
   sequence extra_due_s;
      fn_c[0] == FN_PWM && run_r[0] && run_nxt[0] && !tog_r[0] &&
         per_r[0] && pwm_act_r[0][PWM_AD] &&
         cnt_r[0] == {1'b0, pwm_act_r[0][7:PWM_DUTY0]};
   endsequence

   run_clear_a:
   assert property (!run_r[0] |-> cnt_r[0] == CNT_ZERO)
      else $error("stopped channel holds a count");
   mode_lock_a:
   assert property (acc_wr && idx == IDX_MODE[0] && run_r[0] |=>
      $stable(mode_r[0])) else $error("mode changed while running");
   match_clear_a:
   assert property (match_c[0] |=> match_interrupt[0] &&
      (cnt_r[0] == CNT_ZERO || !run_r[0])) else $error("match lost");
   dbuf_hold_a:
   assert property (dbuf_wr_s |=> $stable(cmp_act_r[0]) &&
      cmp_buf_r[0] == $past(wdat)) else $error("buffer bypassed");
   dbuf_stop_a:
   assert property (acc_wr && idx == IDX_CMP[0] && !run_r[0] |=>
      cmp_act_r[0] == cmp_buf_r[0]) else $error("stopped load split");
   direct_wr_a:
   assert property (acc_wr && idx == IDX_CMP[0] && !mode_r[0].dbe |=>
      cmp_act_r[0] == $past(wdat)) else $error("direct write lost");
   read_back_a:
   assert property (setup && idx == IDX_CMP[0] |=>
      apb_rsp.prdata[7:0] == $past(cmp_buf_r[0]) && apb_rsp.pready)
      else $error("compare read mismatch");
   wrap_quiet_a:
   assert property (fn_c[0] == FN_TIMER && run_r[0] && tk_c[0] &&
      cnt_r[0] == 8'hff && !match_c[0] |=> !match_interrupt[0] &&
      cnt_r[0] == CNT_ZERO) else $error("wrap raised interrupt");
   pwm_irq_a:
   assert property (first_ovf_s |=> !match_interrupt[0] && per_r[0] &&
      cnt_r[0] == CNT_ZERO) else $error("odd overflow interrupted");
   and_out_a:
   assert property (and_r |=> pwm_output_pin[1] ==
      $past(out_c[0] & out_c[1]) && pwm_output_pin[0])
      else $error("AND output wrong");
   idle_level_a:
   assert property (!run_r[0] && !and_r |=> pwm_output_pin[0] ==
      $past(mode_r[0].tff)) else $error("idle level wrong");
   // equal direct write must not wait for the next source tick
   eq_match_a:
   assert property (eq_wr_s |=> match_interrupt[0] && cnt_r[0] == CNT_ZERO)
      else $error("equal write missed match");
   event_step_a:
   assert property (fn_c[0] == FN_EVENT && run_r[0] && run_nxt[0] &&
      evt_fall[0] && !match_c[0] |=> cnt_r[0] == $past(cnt_r[0]) + 8'h01)
      else $error("event edge not counted");
   sync_fall_a:
   assert property ($fell(evt_s2_r[0]) |-> evt_fall[0])
      else $error("synchronised fall lost");
   extra_pulse_a:
   assert property (extra_due_s |=> !tog_r[0])
      else $error("extra count not added");
   pwm_wrap_a:
   assert property (fn_c[0] == FN_PWM && run_r[0] && run_nxt[0] && tk_c[0] &&
      cnt_r[0] == PWM_LAST |=> cnt_r[0] == CNT_ZERO && !tog_r[0])
      else $error("period end not restored");
   slow_src_a:
   assert property (sys_r[SC_SLOW] && !mode_r[0].ein |-> !tk_c[0] ||
      lft != 3'b000) else $error("slow mode ticked off the lf clock");
   // channel one shares the logic; spot checks only
   ch1_clear_a:
   assert property (!run_r[1] |-> cnt_r[1] == CNT_ZERO)
      else $error("stopped channel one holds a count");
   ch1_match_a:
   assert property (match_c[1] |=> match_interrupt[1])
      else $error("channel one match lost");
endmodule : tmr_pair

// ==== rtl/tmr_pair_pkg.sv ====
/*
 Constants, field layouts and carrier types for the 8-bit timer pair.
 Assumes one 20 MHz gear clock and an APB master with 32-bit data.
*/
package tmr_pair_pkg;
   localparam int AW = 12;
   // word indices; byte address is four times the index
   localparam logic [9:0] IDX_CMP [2] = '{10'h020, 10'h021};
   localparam logic [9:0] IDX_MODE [2] = '{10'h022, 10'h023};
   localparam logic [9:0] IDX_CNT [2] = '{10'h024, 10'h025};
   localparam logic [9:0] IDX_PWM [2] = '{10'h028, 10'h029};
   localparam logic [9:0] IDX_PCTRL = 10'h02c;
   localparam logic [9:0] IDX_SYS = 10'h02d;

   localparam logic [7:0] RST_PWM = 8'hff;
   localparam logic [7:0] RST_CMP = 8'h00;
   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic [7:0] CNT_ZERO = 8'h00;
   localparam logic [7:0] PWM_LAST = 8'h7f;

   localparam int PC_RUN0 = 0;
   localparam int PC_CAS = 2;
   localparam int PC_AND = 3;
   localparam int SC_LFDIV = 0;
   localparam int SC_SLOW = 1;
   localparam int PWM_AD = 0;
   localparam int PWM_DUTY0 = 1;

   localparam logic [1:0] TCM_PWM = 2'b10;
   localparam logic [1:0] TCM_PPG = 2'b11;

   // low-frequency edge counts per tick
   localparam logic [3:0] LF_DIV16 = 4'hf;
   localparam logic [3:0] LF_DIV8 = 4'h7;
   localparam logic [3:0] LF_DIV4 = 4'h3;

   typedef struct packed {
      logic dbe;
      logic tff;
      logic [2:0] tck;
      logic ein;
      logic [1:0] tcm;
   } mode_t;

   typedef enum logic [3:0] {
      FN_IDLE = 4'b0001,
      FN_TIMER = 4'b0010,
      FN_EVENT = 4'b0100,
      FN_PWM = 4'b1000
   } ch_fn_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [AW-1:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } apb_rsp_t;
endpackage : tmr_pair_pkg

// ==== verification/tmr_far_side.sv ====
/*
 far side of tmr_pair: event pulse source on channel 0, a free-running
 low-frequency clock, and a load that times rises of channel 0's pin.
 assumes clk_sys is the device's gear clock.
*/
`timescale 1ns/100ps
module tmr_far_side (
   input wire logic clk_sys,
   input wire logic ev_go,
   input wire logic [7:0] ev_n,
   output logic ev_busy,
   output logic [1:0] event_pin,
   output logic lf_clk_pin,
   input wire logic [1:0] pwm_output_pin,
   output logic rise_seen,
   output logic [15:0] rise_per
);
   logic [7:0] left = 8'h00;
   logic [2:0] ph = 3'h0;
   logic [2:0] lf = 3'h0;
   logic last = 1'b0;
   logic [15:0] age = 16'h0000;
   initial begin
      event_pin = 2'b11;
      rise_seen = 1'b0;
      rise_per = 16'h0000;
   end
   assign ev_busy = (left != 8'h00);
   // the oscillator never pauses, so its clock runs between uses too
   assign lf_clk_pin = lf[2];
   always @(posedge clk_sys) begin
      lf <= lf + 3'h1;
      if (ev_go && !ev_busy) begin
         left <= ev_n;
         ph <= 3'h0;
      end else if (ev_busy) begin
         // three low, three high: slower than the fastest legal rate
         event_pin[0] <= (ph >= 3'h3);
         ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
         if (ph == 3'h5) left <= left - 8'h01;
      end
      last <= pwm_output_pin[0];
      rise_seen <= pwm_output_pin[0] && !last;
      age <= (pwm_output_pin[0] && !last) ? 16'h0001 : age + 16'h0001;
      if (pwm_output_pin[0] && !last) rise_per <= age;
   end
endmodule : tmr_far_side

// ==== verification/tmr_pair_bench.sv ====
/*
 self-checking bench for tmr_pair: read data and interrupt gaps are
 noted in queues and compared when they appear. needs tmr_far_side.
*/
`timescale 1ns/100ps
module tmr_pair_bench;
   import tmr_pair_pkg::*;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   apb_req_t req = '0;
   apb_rsp_t rsp;
   logic [1:0] event_pin;
   logic [1:0] pwm_output_pin;
   logic [1:0] match_interrupt;
   logic lf_clk_pin;
   logic ev_go = 1'b0;
   logic ev_busy;
   logic rise_seen;
   logic [7:0] ev_n = 8'h00;
   logic [15:0] rise_per;
   logic [32:0] rq[$];
   int gq[$];
   int fail_count = 0;
   int checks_done = 0;
   int ic = 0;
   int since = 0;
   int ic1 = 0;
   int since1 = 0;
   int cyc = 0;
   int c;
   int p1;
   int p2;

   always #25 clk_sys = ~clk_sys;

   tmr_pair tmr_pair_i (.clk_sys(clk_sys), .rst(rst), .apb_req(req),
      .apb_rsp(rsp), .event_pin(event_pin), .lf_clk_pin(lf_clk_pin),
      .pwm_output_pin(pwm_output_pin), .match_interrupt(match_interrupt));
   tmr_far_side tmr_far_side_i (.clk_sys(clk_sys), .ev_go(ev_go),
      .ev_n(ev_n), .ev_busy(ev_busy), .event_pin(event_pin),
      .lf_clk_pin(lf_clk_pin), .pwm_output_pin(pwm_output_pin),
      .rise_seen(rise_seen), .rise_per(rise_per));

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test

   task automatic chk_num(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t count %0d exp %0d", $time, got, exp);
      end
   endtask : chk_num

   task automatic chk_rd(input logic [32:0] got, input logic [32:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t read %h exp %h", $time, got, exp);
      end
   endtask : chk_rd

   task automatic chk_pin(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t pin %b exp %b", $time, got, exp);
      end
   endtask : chk_pin

   // released for one idle cycle so no signal is driven twice at an edge
   task automatic xfer(input logic w, input logic [9:0] i,
      input logic [7:0] d);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {i, 2'b00},
         pwdata: {24'h0, d}};
      @(posedge clk_sys);
      req.penable <= 1'b1;
      do @(posedge clk_sys); while (rsp.pready !== 1'b1);
      req <= '0;
      @(posedge clk_sys);
   endtask : xfer

   task automatic wr(input logic [9:0] i, input logic [7:0] d);
      xfer(1'b1, i, d);
   endtask : wr

   task automatic rd(input logic [9:0] i, input logic [7:0] e,
      input logic er = 1'b0);
      rq.push_back({er, 24'h0, e});
      xfer(1'b0, i, 8'h00);
   endtask : rd

   task automatic wait_ic(input int n);
      int t;
      t = ic + n;
      while (ic < t) @(posedge clk_sys);
   endtask : wait_ic

   task automatic send(input logic [7:0] n);
      ev_n <= n;
      ev_go <= 1'b1;
      @(posedge clk_sys);
      ev_go <= 1'b0;
      @(posedge clk_sys);
      while (ev_busy) @(posedge clk_sys);
      repeat (6) @(posedge clk_sys);
   endtask : send

   task automatic rise(output int p);
      do @(posedge clk_sys); while (rise_seen !== 1'b1);
      p = rise_per;
   endtask : rise

   task automatic per(input logic [7:0] m, input logic [7:0] k,
      input int gap);
      wr(IDX_MODE[0], m);
      wr(IDX_CMP[0], k);
      wr(IDX_PCTRL, 8'h01);
      wait_ic(1);
      gq.push_back(gap);
      wait_ic(1);
      wr(IDX_MODE[0], 8'hc2);
      rd(IDX_MODE[0], m);
      wr(IDX_PCTRL, 8'h00);
      rd(IDX_CNT[0], 8'h00);
   endtask : per

   task automatic dbl(input logic dbe);
      wr(IDX_PCTRL, 8'h00);
      wr(IDX_MODE[0], {dbe, 7'h38});
      wr(IDX_CMP[0], 8'd20);
      wr(IDX_PCTRL, 8'h01);
      wait_ic(1);
      wr(IDX_CMP[0], 8'd30);
      if (dbe) gq.push_back(21);
      gq.push_back(31);
      wait_ic(dbe ? 2 : 1);
      rd(IDX_CMP[0], 8'd30);
   endtask : dbl

   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         $display("MISMATCH t=%0t timeout", $time);
         fail_count++;
         finish_test();
      end
      if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1)
         chk_rd({rsp.pslverr, rsp.prdata}, rq.pop_front());
      if (match_interrupt[0] === 1'b1) begin
         ic <= ic + 1;
         since <= 1;
         if (gq.size() > 0) chk_num(since, gq.pop_front());
      end else since <= since + 1;
      // channel one only ever runs with compare 9 at full gear rate
      if (match_interrupt[1] === 1'b1) begin
         ic1 <= ic1 + 1;
         since1 <= 1;
         if (ic1 > 0) chk_num(since1, 10);
      end else since1 <= since1 + 1;
   end

   initial begin
      void'($urandom(27557));
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      rd(IDX_PWM[0], 8'hff);
      rd(IDX_PWM[1], 8'hff);
      rd(10'h03f, 8'h00, 1'b1);
      c = $urandom;
      wr(IDX_PWM[1], 8'(c));
      rd(IDX_PWM[1], 8'(c));
      for (int i = 0; i < 4; i++) begin
         c = 2 + $urandom % 8;
         per({2'b00, 3'(7 - i), 3'b000}, 8'(c),
            (c + 1) * ((i == 3) ? 16 : (1 << i)));
      end
      wr(IDX_SYS, 8'h01);
      for (int i = 0; i < 2; i++) per({5'h00, 3'(i)} << 3, 8'h01,
         (i == 1) ? 128 : 256);
      wr(IDX_SYS, 8'h02);
      per(8'h38, 8'h01, 64);
      wr(IDX_SYS, 8'h00);
      dbl(1'b1);
      dbl(1'b0);
      wait_ic(1);
      repeat (10) @(posedge clk_sys);
      wr(IDX_CMP[0], 8'h05);
      gq.push_back(262);
      wait_ic(1);
      wr(IDX_PCTRL, 8'h00);
      wr(IDX_MODE[0], 8'h04);
      wr(IDX_CMP[0], 8'h03);
      wr(IDX_PCTRL, 8'h01);
      p1 = ic;
      send(8'h02);
      rd(IDX_CNT[0], 8'h02);
      send(8'h02);
      rd(IDX_CNT[0], 8'h00);
      chk_num(ic - p1, 1);
      wr(IDX_PCTRL, 8'h00);
      wr(IDX_MODE[1], 8'h38);
      wr(IDX_CMP[1], 8'h09);
      wr(IDX_PCTRL, 8'h02);
      while (ic1 < 3) @(posedge clk_sys);
      wr(IDX_PCTRL, 8'h00);
      wr(IDX_MODE[1], 8'h42);
      wr(IDX_MODE[0], 8'h7a);
      repeat (3) @(posedge clk_sys);
      chk_pin(pwm_output_pin[0], 1'b1);
      chk_pin(pwm_output_pin[1], 1'b1);
      wr(IDX_MODE[0], 8'h3a);
      wr(IDX_PCTRL, 8'h08);
      repeat (3) @(posedge clk_sys);
      chk_pin(pwm_output_pin[1], 1'b0);
      wr(IDX_PCTRL, 8'h00);
      for (int ad = 0; ad < 2; ad++) begin
         wr(IDX_PWM[0], {7'(10 + $urandom % 90), 1'(ad)});
         wr(IDX_PCTRL, 8'h01);
         rise(p1);
         rise(p1);
         rise(p2);
         chk_num(p1 + p2, 256);
         chk_num((p1 > p2) ? p1 - p2 : p2 - p1, 2 * ad);
         wait_ic(1);
         gq.push_back(256);
         wait_ic(1);
         wr(IDX_PCTRL, 8'h00);
         repeat (3) @(posedge clk_sys);
         chk_pin(pwm_output_pin[0], 1'b0);
      end
      finish_test();
   end
endmodule : tmr_pair_bench
